// ===== cwrc_defs.vh
// constants for the working register context block
`ifndef CWRC_DEFS_VH
`define CWRC_DEFS_VH

// ----------------------------------------------------------------
// register map (byte addresses on the apb port)
// ----------------------------------------------------------------
`define CWRC_OFF_CFG      12'h000
`define CWRC_OFF_STAT     12'h004
`define CWRC_OFF_PC       12'h008
`define CWRC_OFF_SWAP     12'h00C
`define CWRC_OFF_WREG     12'h040
`define CWRC_OFF_WREG_END 12'h07C

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define CWRC_CFG_ALT1_LSB 0
`define CWRC_CFG_ALT2_LSB 4
`define CWRC_STAT_CUR_LSB 0
`define CWRC_STAT_MAN_LSB 8
`define CWRC_CFG_RST      8'h00
`define CWRC_PC_RST       23'h000000
`define CWRC_SP_RST       16'h0000
`define CWRC_CTX_PRIMARY  3'h0

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define CWRC_DW           16
`define CWRC_PCW          23
`define CWRC_NSETS        3
`define CWRC_NLOW         15
`define CWRC_SP_IDX       4'hF

`endif

// ===== cwrc_regmem.v
// banked storage for the lower fifteen working registers of all sets
`timescale 1ns/1ps
module cwrc_regmem (
  input  wire        clk_sys,
  input  wire        clk_en,
  input  wire        we,
  input  wire [5:0]  waddr,
  input  wire [15:0] wdata,
  input  wire [5:0]  raddr,
  output reg  [15:0] rdata
);

  // ------------------------------------------------------------
  // memory, no reset: contents persist across context changes
  // ------------------------------------------------------------
  reg [15:0] mem [0:47];

  always @(posedge clk_sys) begin
    if (clk_en) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end

endmodule // cwrc_regmem

// ===== cwrc_ctxsel.v
// context selection from interrupt level, swap command and return
`timescale 1ns/1ps
`include "cwrc_defs.vh"
module cwrc_ctxsel (
  input  wire [2:0] cur_ctx,
  input  wire [7:0] cfg,
  input  wire       irq_enter,
  input  wire [2:0] irq_level,
  input  wire       irq_return,
  input  wire [2:0] ret_ctx,
  input  wire       swap_valid,
  input  wire [2:0] swap_ctx,
  output reg  [2:0] ctx_nxt
);

  // ------------------------------------------------------------
  // interrupt entry picks the set bound to its level, else primary
  // ------------------------------------------------------------
  wire [2:0] alt1_lvl = cfg[`CWRC_CFG_ALT1_LSB +: 3];
  wire [2:0] alt2_lvl = cfg[`CWRC_CFG_ALT2_LSB +: 3];
  wire       lvl_ok   = (irq_level >= 3'h1) && (irq_level <= 3'h6);

  always @* begin
    ctx_nxt = cur_ctx;
    if (irq_enter) begin
      ctx_nxt = `CWRC_CTX_PRIMARY;
      if (lvl_ok && (alt1_lvl == irq_level)) begin
        ctx_nxt = 3'h1;
      end else if (lvl_ok && (alt2_lvl == irq_level)) begin
        ctx_nxt = 3'h2;
      end
    end else if (irq_return) begin
      ctx_nxt = (ret_ctx < 3'h3) ? ret_ctx : `CWRC_CTX_PRIMARY;
    end else if (swap_valid && (swap_ctx < 3'h3)) begin
      ctx_nxt = swap_ctx;
    end
  end

endmodule // cwrc_ctxsel

// ===== cwrc_top.v
// working register file with alternate contexts, pc and apb access
//
// Behaviour
// - sixteen 16-bit working registers usable as data, pointer or offset
// - register fifteen is the stack pointer for pushes and pops
// - two alternate sets of registers zero to fourteen, stack pointer shared
// - alternate set contents persist between uses, never cleared
// - per alternate set a 3-bit field binds it to interrupt level 1-6
// - a swap command selects a register set manually
// - status shows current set and last manually selected set
// - program counter is 23 bits, addressing 24-bit program words
// - data-space access to registers 0-14 uses the active context
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "cwrc_defs.vh"
module cwrc_top (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        clk_en,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // execution unit port
  input  wire        ex_rd_en,
  input  wire [3:0]  ex_rd_idx,
  output reg  [15:0] ex_rd_data,
  output reg         ex_rd_valid,
  input  wire        ex_wr_en,
  input  wire [3:0]  ex_wr_idx,
  input  wire [15:0] ex_wr_data,
  input  wire        sp_push,
  input  wire        sp_pop,
  input  wire        pc_load,
  input  wire [22:0] pc_target,
  input  wire        pc_step,
  input  wire        swap_valid,
  input  wire [2:0]  swap_ctx,
  // interrupt logic
  input  wire        irq_enter,
  input  wire [2:0]  irq_level,
  input  wire        irq_return,
  input  wire [2:0]  ret_ctx,
  output reg  [2:0]  cur_ctx,
  output reg  [2:0]  man_ctx,
  output reg  [15:0] sp_out,
  output reg  [22:0] pc_out
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  reg  [7:0]  cfg_r;
  reg  [15:0] sp_r;
  reg  [22:0] pc_r;
  reg  [2:0]  cur_r;
  reg  [2:0]  man_r;
  wire [2:0]  ctx_nxt;

  // apb access decode: the access phase takes three cycles so that the
  // banked read has a registered data path
  localparam ST_IDLE = 2'b00;
  localparam ST_WAIT = 2'b01;
  localparam ST_DONE = 2'b10;
  reg  [1:0]  st_r;
  reg  [1:0]  st_nxt;

  wire        acc      = psel && penable;
  wire        is_wreg  = (paddr >= `CWRC_OFF_WREG) && (paddr <= `CWRC_OFF_WREG_END)
                         && (paddr[1:0] == 2'b00);
  wire [3:0]  bus_idx  = paddr[5:2];
  wire        bus_sp   = is_wreg && (bus_idx == `CWRC_SP_IDX);
  wire        mapped   = is_wreg || (paddr == `CWRC_OFF_CFG) || (paddr == `CWRC_OFF_STAT)
                         || (paddr == `CWRC_OFF_PC) || (paddr == `CWRC_OFF_SWAP);
  // a write lands only at the edge where the master sees pready high
  wire        bus_wr   = acc && pwrite && (st_r == ST_DONE) && mapped;

  // ------------------------------------------------------------
  // bank memory: index = context * 16 + register
  // ------------------------------------------------------------
  wire        ex_low_wr = ex_wr_en && (ex_wr_idx != `CWRC_SP_IDX);
  wire        bus_low_wr = bus_wr && is_wreg && !bus_sp;
  wire        mem_we    = ex_low_wr || bus_low_wr;
  wire [3:0]  mem_widx  = ex_low_wr ? ex_wr_idx : bus_idx;
  wire [15:0] mem_wdat  = ex_low_wr ? ex_wr_data : pwdata[15:0];
  wire [5:0]  mem_waddr = {cur_r[1:0], mem_widx};
  wire        bus_rd_sel = acc && !pwrite && is_wreg && (st_r == ST_IDLE);
  wire [3:0]  mem_ridx  = bus_rd_sel ? bus_idx : ex_rd_idx;
  wire [5:0]  mem_raddr = {cur_r[1:0], mem_ridx};
  wire [15:0] mem_rdata;
  reg         ex_rd_sp_r;
  reg         rd_pend_r;

  cwrc_regmem u_mem (
    .clk_sys (clk_sys),
    .clk_en  (clk_en),
    .we      (mem_we),
    .waddr   (mem_waddr),
    .wdata   (mem_wdat),
    .raddr   (mem_raddr),
    .rdata   (mem_rdata)
  );

  cwrc_ctxsel u_sel (
    .cur_ctx    (cur_r),
    .cfg        (cfg_r),
    .irq_enter  (irq_enter),
    .irq_level  (irq_level),
    .irq_return (irq_return),
    .ret_ctx    (ret_ctx),
    .swap_valid (swap_valid),
    .swap_ctx   (swap_ctx),
    .ctx_nxt    (ctx_nxt)
  );

  // ------------------------------------------------------------
  // context, stack pointer and program counter
  // ------------------------------------------------------------
  wire swap_take = swap_valid && !irq_enter && !irq_return && (swap_ctx < 3'h3);
  wire bus_swap  = bus_wr && (paddr == `CWRC_OFF_SWAP) && (pwdata[2:0] < 3'h3);

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cur_r <= `CWRC_CTX_PRIMARY;
      man_r <= `CWRC_CTX_PRIMARY;
      cfg_r <= `CWRC_CFG_RST;
      sp_r  <= `CWRC_SP_RST;
      pc_r  <= `CWRC_PC_RST;
    end else if (clk_en) begin
      if (bus_swap && !irq_enter && !irq_return && !swap_valid) begin
        cur_r <= pwdata[2:0];
        man_r <= pwdata[2:0];
      end else begin
        cur_r <= ctx_nxt;
        if (swap_take) begin
          man_r <= swap_ctx;
        end
      end
      if (bus_wr && (paddr == `CWRC_OFF_CFG)) begin
        cfg_r <= {1'b0, pwdata[6:4], 1'b0, pwdata[2:0]};
      end
      // stack pointer is shared by every set
      if (ex_wr_en && (ex_wr_idx == `CWRC_SP_IDX)) begin
        sp_r <= ex_wr_data;
      end else if (sp_push && !sp_pop) begin
        sp_r <= sp_r + 16'h0002;
      end else if (sp_pop && !sp_push) begin
        sp_r <= sp_r - 16'h0002;
      end else if (bus_wr && bus_sp) begin
        sp_r <= pwdata[15:0];
      end
      // word-aligned 23-bit counter, steps two per instruction word
      if (pc_load) begin
        pc_r <= {pc_target[22:1], 1'b0};
      end else if (pc_step) begin
        pc_r <= pc_r + 23'h000002;
      end else if (bus_wr && (paddr == `CWRC_OFF_PC)) begin
        pc_r <= {pwdata[22:1], 1'b0};
      end
    end
  end

  // ------------------------------------------------------------
  // execution unit read port: any of the sixteen as operand
  // ------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ex_rd_sp_r  <= 1'b0;
      rd_pend_r   <= 1'b0;
      ex_rd_valid <= 1'b0;
      ex_rd_data  <= 16'h0000;
    end else if (clk_en) begin
      ex_rd_sp_r  <= (ex_rd_idx == `CWRC_SP_IDX);
      rd_pend_r   <= ex_rd_en && !bus_rd_sel;
      ex_rd_valid <= rd_pend_r;
      // second stage keeps the port a flop, at the cost of one more cycle
      ex_rd_data  <= ex_rd_sp_r ? sp_r : mem_rdata;
    end
  end

  // ------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------
  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (acc) begin
          st_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        st_nxt = ST_DONE;
      end
      ST_DONE: begin
        st_nxt = ST_IDLE;
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  reg [31:0] rd_word;
  always @* begin
    rd_word = 32'h00000000;
    if (is_wreg) begin
      rd_word = bus_sp ? {16'h0000, sp_r} : {16'h0000, mem_rdata};
    end else if (paddr == `CWRC_OFF_CFG) begin
      rd_word = {24'h000000, cfg_r};
    end else if (paddr == `CWRC_OFF_STAT) begin
      rd_word = {21'h000000, man_r, 5'h00, cur_r};
    end else if (paddr == `CWRC_OFF_PC) begin
      rd_word = {9'h000, pc_r};
    end else if (paddr == `CWRC_OFF_SWAP) begin
      rd_word = {29'h00000000, man_r};
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r    <= ST_IDLE;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (clk_en) begin
      st_r    <= st_nxt;
      pready  <= (st_r == ST_WAIT);
      pslverr <= (st_r == ST_WAIT) && !mapped;
      if (st_r == ST_WAIT) begin
        prdata <= (!pwrite && mapped) ? rd_word : 32'h00000000;
      end
    end
  end

  // ------------------------------------------------------------
  // registered status outputs
  // ------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cur_ctx <= `CWRC_CTX_PRIMARY;
      man_ctx <= `CWRC_CTX_PRIMARY;
      sp_out  <= `CWRC_SP_RST;
      pc_out  <= `CWRC_PC_RST;
    end else if (clk_en) begin
      cur_ctx <= cur_r;
      man_ctx <= man_r;
      sp_out  <= sp_r;
      pc_out  <= pc_r;
    end
  end

endmodule // cwrc_top

// ===== cwrc_exec_model.sv
// model of the execution unit and interrupt logic facing the block
`timescale 1ns/1ps
module cwrc_exec_model (
  input  wire        clk_sys,
  input  wire [15:0] ex_rd_data,
  input  wire        ex_rd_valid,
  output reg         ex_rd_en,
  output reg  [3:0]  ex_rd_idx,
  output reg         ex_wr_en,
  output reg  [3:0]  ex_wr_idx,
  output reg  [15:0] ex_wr_data,
  output reg         sp_push,
  output reg         sp_pop,
  output reg         pc_load,
  output reg  [22:0] pc_target,
  output reg         pc_step,
  output reg         swap_valid,
  output reg  [2:0]  swap_ctx,
  output reg         irq_enter,
  output reg  [2:0]  irq_level,
  output reg         irq_return,
  output reg  [2:0]  ret_ctx
);
  initial begin
    {ex_rd_en, ex_wr_en, sp_push, sp_pop, pc_load, pc_step} = 6'h00;
    {swap_valid, irq_enter, irq_return} = 3'h0;
    {ex_rd_idx, ex_wr_idx, ex_wr_data, pc_target} = 47'h0;
    {swap_ctx, irq_level, ret_ctx} = 9'h000;
  end
  // data is inverted once released so a stale value never looks valid
  task wr(input [3:0] i, input [15:0] d);
    begin
      @(posedge clk_sys);
      ex_wr_en   <= 1'b1;
      ex_wr_idx  <= i;
      ex_wr_data <= d;
      @(posedge clk_sys);
      ex_wr_en   <= 1'b0;
      ex_wr_data <= ~d;
    end
  endtask
  task rd(input [3:0] i, output [15:0] d, output ok);
    integer n;
    begin
      @(posedge clk_sys);
      ex_rd_en  <= 1'b1;
      ex_rd_idx <= i;
      @(posedge clk_sys);
      ex_rd_en <= 1'b0;
      ok = 1'b0;
      d = 16'h0000;
      for (n = 0; n < 4 && !ok; n = n + 1) begin
        @(posedge clk_sys);
        ok = (ex_rd_valid === 1'b1);
        d = ex_rd_data;
      end
    end
  endtask
  // one-cycle pulse, then room for the context to reach the outputs
  task ctl(input [6:0] v, input [2:0] a, input [22:0] t);
    begin
      @(posedge clk_sys);
      {irq_return, irq_enter, swap_valid, pc_load, pc_step, sp_pop, sp_push} <= v;
      swap_ctx  <= a;
      irq_level <= a;
      ret_ctx   <= a;
      pc_target <= t;
      @(posedge clk_sys);
      {irq_return, irq_enter, swap_valid, pc_load, pc_step, sp_pop, sp_push} <= 7'h00;
      repeat (2) @(posedge clk_sys);
    end
  endtask
endmodule // cwrc_exec_model

// ===== cwrc_checker.sv
// port assertions for the context block
`timescale 1ns/1ps
module cwrc_checker (
  input wire        clk_sys,
  input wire        rst,
  input wire        clk_en,
  input wire        psel,
  input wire        penable,
  input wire        pready,
  input wire        pslverr,
  input wire        ex_rd_en,
  input wire        ex_rd_valid,
  input wire        ex_wr_en,
  input wire        sp_push,
  input wire        sp_pop,
  input wire        pc_load,
  input wire        pc_step,
  input wire [22:0] pc_target,
  input wire        swap_valid,
  input wire [2:0]  swap_ctx,
  input wire        irq_enter,
  input wire        irq_return,
  input wire [2:0]  cur_ctx,
  input wire [2:0]  man_ctx,
  input wire [15:0] sp_out,
  input wire [22:0] pc_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_reset_clears: assert property (disable iff (1'b0) rst ##1 rst |->
    !cur_ctx && !man_ctx && !sp_out && !pc_out) else $error("reset state wrong");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_ready_time: assert property (psel && !penable ##1 psel && penable |-> ##2 pready)
    else $error("apb answer late");
  a_err_ready: assert property (pslverr |-> pready) else $error("lone pslverr");
  a_rd_answer: assert property (ex_rd_en && clk_en && !psel ##1 clk_en |=> ex_rd_valid)
    else $error("read answer missing");
  a_rd_cause: assert property (ex_rd_valid |-> $past(ex_rd_en, 2)) else $error("stray valid");
  a_sp_push: assert property (sp_push && !sp_pop && !ex_wr_en && clk_en ##1 clk_en
    |=> sp_out == $past(sp_out) + 16'h2) else $error("push step wrong");
  a_sp_pop: assert property (sp_pop && !sp_push && !ex_wr_en && clk_en ##1 clk_en
    |=> sp_out == $past(sp_out) - 16'h2) else $error("pop step wrong");
  a_pc_step: assert property (pc_step && !pc_load && clk_en ##1 clk_en
    |=> pc_out == $past(pc_out) + 23'h2) else $error("pc step wrong");
  a_pc_load: assert property (pc_load && clk_en ##1 clk_en
    |=> pc_out == ($past(pc_target, 2) & 23'h7FFFFE)) else $error("pc load wrong");
  a_swap_sel: assert property (swap_valid && swap_ctx < 3'h3 && !irq_enter
    && !irq_return && clk_en ##1 clk_en |=> cur_ctx == $past(swap_ctx, 2)
    && man_ctx == $past(swap_ctx, 2)) else $error("swap not applied");
  a_ctx_range: assert property (cur_ctx < 3'h3 && man_ctx < 3'h3)
    else $error("context out of range");
endmodule // cwrc_checker
bind cwrc_top cwrc_checker chk_u (.*);

// ===== tb_cwrc_top.sv
// self-checking testbench for the working register context block
`timescale 1ns/1ps
`include "cwrc_defs.vh"
module tb_cwrc_top;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        clk_en = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic        pready, pslverr, ex_rd_en, ex_rd_valid, ex_wr_en, sp_push, sp_pop, ev;
  logic        pc_load, pc_step, swap_valid, irq_enter, irq_return;
  logic [3:0]  ex_rd_idx, ex_wr_idx;
  logic [15:0] ex_rd_data, ex_wr_data, sp_out, dv;
  logic [22:0] pc_target, pc_out;
  logic [2:0]  swap_ctx, irq_level, ret_ctx, cur_ctx, man_ctx;
  integer      miscompares = 0;
  integer      total_checks = 0;
  integer      i;
  always #10 clk_sys = ~clk_sys;
  cwrc_top dut_u (.*);
  cwrc_exec_model ex_u (.*);
  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task chk(input string nm, input [31:0] x, input [31:0] s);
    begin
      total_checks = total_checks + 1;
      if (s !== x) begin
        miscompares = miscompares + 1;
        $display("FAIL %s exp %h got %h", nm, x, s);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clk_sys);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge clk_sys);
        n = n + 1;
      end while (pready !== 1'b1 && n < 16);
      rv = prdata;
      ev = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 16) begin
        miscompares = miscompares + 1;
        final_report;
      end
    end
  endtask
  task ctxs(input [2:0] c, input [2:0] m);
    begin
      chk("cur_ctx", 32'(c), 32'(cur_ctx));
      chk("man_ctx", 32'(m), 32'(man_ctx));
      apb(1'b0, `CWRC_OFF_STAT, 32'h0);
      chk("status", {21'h0, m, 5'h0, c}, rv);
    end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    ctxs(3'h0, 3'h0);
    apb(1'b1, `CWRC_OFF_CFG, 32'h31);
    apb(1'b0, `CWRC_OFF_CFG, 32'h0);
    chk("cfg", 32'h31, rv);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped", 32'h80000000, {ev, rv[30:0]});
    for (i = 0; i < 15; i = i + 1) begin
      ex_u.wr(i[3:0], 16'hA000 + i[15:0]);
      apb(1'b0, `CWRC_OFF_WREG + 12'(i * 4), 32'h0);
      chk("apb_wreg", 32'hA000 + i, rv);
      ex_u.rd(i[3:0], dv, ev);
      chk("ex_rd", {1'b1, 15'h0, 16'hA000 + i[15:0]}, {ev, 15'h0, dv});
    end
    ex_u.ctl(7'h10, 3'h1, 23'h0);
    ctxs(3'h1, 3'h1);
    apb(1'b1, `CWRC_OFF_WREG + 12'h00C, 32'h2222);
    ex_u.rd(4'h3, dv, ev);
    chk("alt_r3", 32'h2222, 32'(dv));
    ex_u.ctl(7'h10, 3'h0, 23'h0);
    ex_u.rd(4'h3, dv, ev);
    chk("pri_r3", 32'hA003, 32'(dv));
    // set 2 is bound to level 3, set 1 to level 1
    ex_u.ctl(7'h20, 3'h3, 23'h0);
    ctxs(3'h2, 3'h0);
    ex_u.ctl(7'h20, 3'h1, 23'h0);
    ctxs(3'h1, 3'h0);
    ex_u.rd(4'h3, dv, ev);
    chk("persist", 32'h2222, 32'(dv));
    ex_u.ctl(7'h40, 3'h0, 23'h0);
    apb(1'b1, `CWRC_OFF_SWAP, 32'h2);
    repeat (2) @(posedge clk_sys);
    ctxs(3'h2, 3'h2);
    // level six is bound to no set, so entry falls back to the primary set
    ex_u.ctl(7'h20, 3'h6, 23'h0);
    ctxs(3'h0, 3'h2);
    ex_u.ctl(7'h10, 3'h7, 23'h0);
    ctxs(3'h0, 3'h2);
    ex_u.wr(4'hF, 16'h0100);
    ex_u.ctl(7'h01, 3'h0, 23'h0);
    ex_u.ctl(7'h01, 3'h0, 23'h0);
    ex_u.ctl(7'h02, 3'h0, 23'h0);
    chk("sp_out", 32'h0102, 32'(sp_out));
    ex_u.rd(4'hF, dv, ev);
    chk("sp_rd", {1'b1, 15'h0, 16'h0102}, {ev, 15'h0, dv});
    @(posedge clk_sys);
    clk_en <= 1'b0;
    ex_u.ctl(7'h01, 3'h0, 23'h0);
    clk_en <= 1'b1;
    chk("sp_frozen", 32'h0102, 32'(sp_out));
    ex_u.ctl(7'h10, 3'h0, 23'h0);
    apb(1'b0, `CWRC_OFF_WREG_END, 32'h0);
    chk("sp_apb", 32'h0102, rv);
    ex_u.ctl(7'h08, 3'h0, 23'h7ABCDF);
    ex_u.ctl(7'h04, 3'h0, 23'h0);
    apb(1'b0, `CWRC_OFF_PC, 32'h0);
    chk("pc", 32'h7ABCE0, rv);
    chk("pc_out", 32'h7ABCE0, 32'(pc_out));
    final_report;
  end
endmodule // tb_cwrc_top
